/* dbu_pkg.sv */
// Shared constants for the debug unlock and breakpoint unit.
// Assumes one 40 MHz core clock shared by both ends.
package dbu_pkg;
	// Clock period in picoseconds
	localparam int CLK_PERIOD_PS = 25000;
	// Reset settling wait, in milliseconds
	localparam int RESET_WAIT_MS = 5;
	// Reset settling wait in core cycles, rounded up
	// Per-millisecond count first, so the product stays inside 32 bits
	localparam int RESET_WAIT_CYC = RESET_WAIT_MS *
		((1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	// Default bit time of the serial debug wire, in core cycles
	localparam int BIT_CYC = 16;
	// Autobaud byte and unlock key bytes
	localparam logic [7:0] AUTOBAUD_BYTE = 8'h80;
	localparam logic [7:0] KEY_BYTE0 = 8'hEB;
	localparam logic [7:0] KEY_BYTE1 = 8'h5A;
	localparam logic [7:0] KEY_BYTE2 = 8'h70;
	localparam logic [7:0] KEY_BYTE3 = 8'hCD;
	// Debugger control write that enters debug mode
	localparam logic [7:0] DEBUG_ENTER_CMD = 8'h80;
	// Break instruction opcode
	localparam logic [7:0] BREAK_OPCODE = 8'h00;
	// Runtime counter limits
	localparam logic [15:0] RUNTIME_MAX = 16'hFFFF;
	localparam logic [15:0] RUNTIME_ZERO = 16'h0000;
	// Autobaud bit count (byte 80H shows seven zero bits after start)
	localparam logic [3:0] AUTOBAUD_LOW_BITS = 4'h8;
endpackage

/* dbu_link_if.sv */
// Link between the debug host and the chip debug unit.
// Assumes open-drain ends; the interface resolves the wire from the enables.
`timescale 1ns/10ps
`default_nettype none
interface dbu_link_if;
	// Shared reset pin, driven low by the host
	logic resetPinN;
	// Debug wire: host and device drive, wire level seen by both
	logic hostDbgOut;
	logic hostDbgOe;
	logic devDbgOut;
	logic devDbgOe;
	logic dbgWire;
	// Wire level: low when any driver pulls low
	assign dbgWire = !((hostDbgOe && !hostDbgOut) ||
		(devDbgOe && !devDbgOut));
	modport device (
		input resetPinN,
		input dbgWire,
		output devDbgOut,
		output devDbgOe
	);
	modport host (
		output resetPinN,
		input dbgWire,
		output hostDbgOut,
		output hostDbgOe
	);
endinterface
`default_nettype wire

/* dbu_device.sv */
// Chip debug unit: unlock of the shared pin, break handling, runtime count.
// Assumes the link wire arrives asynchronously, 8N1 serial, LSB first.
`timescale 1ns/10ps
`default_nettype none
module dbu_device
	import dbu_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Link to the host
	dbu_link_if.device link,
	// Processor side
	input wire logic opcodeValid,
	input wire logic [7:0] opcode,
	input wire logic breakEnable,
	input wire logic leaveDebug,
	output logic cpuIdle,
	output logic breakNop,
	// General-purpose port side of the shared pin
	input wire logic gpioOut,
	input wire logic gpioOe,
	output logic gpioIn,
	// Debug side of the shared pin
	input wire logic dbgTxOut,
	output logic dbgRxIn,
	// Status
	output logic pinIsDebug,
	output logic debugMode,
	output logic [15:0] runtimeCount
);
	// Unlock progress states, Gray coded along the usual path
	typedef enum logic [2:0] {
		UL_AUTOBAUD = 3'h0,
		UL_KEY0 = 3'h1,
		UL_KEY1 = 3'h3,
		UL_KEY2 = 3'h2,
		UL_KEY3 = 3'h6,
		UL_DONE = 3'h7,
		UL_FAIL = 3'h5
	} dbu_unlock_t;

	// Synchronisers for the two pins
	logic [1:0] wireSync_reg;
	logic [1:0] rstPinSync_reg;
	logic wireLvl;
	logic inReset;
	// Autobaud measurement and byte receiver
	logic [15:0] lowCnt_reg;
	logic [15:0] bitCyc_reg;
	logic [15:0] rxCnt_reg;
	logic [3:0] rxBit_reg;
	logic [7:0] rxShift_reg;
	logic rxBusy_reg;
	logic wirePrev_reg;
	logic byteDone;
	logic [7:0] byteVal;
	// Unlock tracking
	dbu_unlock_t ulState_reg, ulState_next;
	logic unlocked_reg;
	// Break handling
	logic breakHit;
	logic debugMode_reg;
	logic [15:0] runtime_reg;
	logic breakNop_reg;

	assign wireLvl = wireSync_reg[1];
	assign inReset = !rstPinSync_reg[1];

	// Two-stage synchronisers; first stage read only by the second
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wireSync_reg <= 2'h3;
			rstPinSync_reg <= 2'h0;
		end else begin
			wireSync_reg <= {wireSync_reg[0], link.dbgWire};
			rstPinSync_reg <= {rstPinSync_reg[0], link.resetPinN};
		end
	end

	// Serial receiver; first byte measures the bit time from its low run
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lowCnt_reg <= 16'h0000;
			bitCyc_reg <= 16'(BIT_CYC);
			rxCnt_reg <= 16'h0000;
			rxBit_reg <= 4'h0;
			rxShift_reg <= 8'h00;
			rxBusy_reg <= 1'b0;
			wirePrev_reg <= 1'b1;
		end else begin
			wirePrev_reg <= wireLvl;
			if (!inReset) begin
				// Receiver is only used for unlock while reset is held
				rxBusy_reg <= 1'b0;
				lowCnt_reg <= 16'h0000;
			end else if (ulState_reg == UL_AUTOBAUD) begin
				// Low run of 80H is start plus seven zero bits
				if (!wireLvl) begin
					lowCnt_reg <= lowCnt_reg + 16'h0001;
				end else if (lowCnt_reg != 16'h0000) begin
					bitCyc_reg <= lowCnt_reg / 16'(AUTOBAUD_LOW_BITS);
					lowCnt_reg <= 16'h0000;
				end
			end else if (!rxBusy_reg) begin
				// Falling edge marks a start bit; sample mid-bit
				if (wirePrev_reg && !wireLvl) begin
					rxBusy_reg <= 1'b1;
					rxBit_reg <= 4'h0;
					rxCnt_reg <= bitCyc_reg + (bitCyc_reg >> 1);
				end
			end else if (rxCnt_reg > 16'h0001) begin
				rxCnt_reg <= rxCnt_reg - 16'h0001;
			end else begin
				rxShift_reg <= {wireLvl, rxShift_reg[7:1]};
				rxCnt_reg <= bitCyc_reg;
				rxBit_reg <= rxBit_reg + 4'h1;
				if (rxBit_reg == 4'h7) begin
					rxBusy_reg <= 1'b0;
				end
			end
		end
	end

	// Byte complete when the eighth data bit is shifted in
	assign byteDone = inReset && rxBusy_reg && rxCnt_reg <= 16'h0001 &&
		rxBit_reg == 4'h7;
	assign byteVal = {wireLvl, rxShift_reg[7:1]};

	// Key comparison, byte by byte
	always_comb begin
		ulState_next = ulState_reg;
		unique case (ulState_reg)
			UL_AUTOBAUD: begin
				// Autobaud done once the low run has ended
				if (lowCnt_reg != 16'h0000 && wireLvl) begin
					ulState_next = UL_KEY0;
				end
			end
			UL_KEY0: if (byteDone) begin
				ulState_next = (byteVal == KEY_BYTE0) ? UL_KEY1 :
					UL_FAIL;
			end
			UL_KEY1: if (byteDone) begin
				ulState_next = (byteVal == KEY_BYTE1) ? UL_KEY2 :
					UL_FAIL;
			end
			UL_KEY2: if (byteDone) begin
				ulState_next = (byteVal == KEY_BYTE2) ? UL_KEY3 :
					UL_FAIL;
			end
			UL_KEY3: if (byteDone) begin
				ulState_next = (byteVal == KEY_BYTE3) ? UL_DONE :
					UL_FAIL;
			end
			UL_DONE: ulState_next = UL_DONE;
			UL_FAIL: ulState_next = UL_FAIL;
			default: ulState_next = UL_FAIL;
		endcase
	end

	// Unlock state; restarts whenever the reset pin goes low again
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ulState_reg <= UL_AUTOBAUD;
		end else if (!inReset) begin
			ulState_reg <= UL_AUTOBAUD;
		end else begin
			ulState_reg <= ulState_next;
		end
	end

	// Pin mode latched once the key completes while reset is held; partial key leaves it GPIO
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			unlocked_reg <= 1'b0;
		end else if (inReset && ulState_reg == UL_DONE) begin
			unlocked_reg <= 1'b1;
		end
	end

	// Shared pin steering: debug only once unlocked
	always_comb begin
		if (unlocked_reg) begin
			link.devDbgOut = 1'b0;
			link.devDbgOe = !dbgTxOut;
		end else begin
			link.devDbgOut = gpioOut;
			link.devDbgOe = gpioOe && !inReset;
		end
	end
	assign gpioIn = unlocked_reg ? 1'b1 : wireLvl;
	assign dbgRxIn = unlocked_reg ? wireLvl : 1'b1;
	assign pinIsDebug = unlocked_reg;

	// Break detect from decoded opcode
	assign breakHit = opcodeValid && opcode == BREAK_OPCODE;

	// Debug mode: entered on enabled break, left by host command
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			debugMode_reg <= 1'b0;
		end else if (breakHit && breakEnable) begin
			debugMode_reg <= 1'b1;
		end else if (leaveDebug) begin
			debugMode_reg <= 1'b0;
		end
	end

	// Disabled break runs as a no-op, flagged for one cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			breakNop_reg <= 1'b0;
		end else begin
			breakNop_reg <= breakHit && !breakEnable;
		end
	end

	// Runtime counter: clears on leaving debug, saturates at max
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			runtime_reg <= RUNTIME_ZERO;
		end else if (debugMode_reg && leaveDebug &&
			!(breakHit && breakEnable)) begin
			runtime_reg <= RUNTIME_ZERO;
		end else if (!debugMode_reg && runtime_reg != RUNTIME_MAX) begin
			runtime_reg <= runtime_reg + 16'h0001;
		end
	end

	assign debugMode = debugMode_reg;
	assign cpuIdle = debugMode_reg;
	assign breakNop = breakNop_reg;
	assign runtimeCount = runtime_reg;
endmodule
`default_nettype wire

/* dbu_host.sv */
// Debug host end: holds reset, sends autobaud and unlock key.
// Assumes the same core clock as the device; the wire level is never read.
`timescale 1ns/10ps
`default_nettype none
module dbu_host
	import dbu_pkg::*;
#(
	// Reset settling wait in cycles; shorten for simulation
	parameter int RESET_WAIT = RESET_WAIT_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// User side
	input wire logic startUnlock,
	output logic busy,
	output logic done,
	// Link to the device
	dbu_link_if.host link
);
	// Host sequence states, Gray coded along the usual path
	typedef enum logic [1:0] {
		HS_IDLE = 2'h0,
		HS_WAIT = 2'h1,
		HS_SEND = 2'h3,
		HS_DONE = 2'h2
	} dbu_hstate_t;

	dbu_hstate_t state_reg;
	logic [31:0] waitCnt_reg;
	logic [15:0] bitCnt_reg;
	logic [3:0] bitIdx_reg;
	logic [2:0] byteIdx_reg;
	logic [9:0] frame;
	logic [7:0] curByte;

	// Byte order: autobaud then key
	always_comb begin
		unique case (byteIdx_reg)
			3'h0: curByte = AUTOBAUD_BYTE;
			3'h1: curByte = KEY_BYTE0;
			3'h2: curByte = KEY_BYTE1;
			3'h3: curByte = KEY_BYTE2;
			3'h4: curByte = KEY_BYTE3;
			// After release: re-autobaud, then the debug entry write
			3'h5: curByte = AUTOBAUD_BYTE;
			default: curByte = DEBUG_ENTER_CMD;
		endcase
	end
	// Stop, data LSB first, start
	assign frame = {1'b1, curByte, 1'b0};

	// Sequencer: reset low, wait, five unlock frames, release, two more
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= HS_IDLE;
			waitCnt_reg <= 32'h00000000;
			bitCnt_reg <= 16'h0000;
			bitIdx_reg <= 4'h0;
			byteIdx_reg <= 3'h0;
		end else begin
			unique case (state_reg)
				HS_IDLE: if (startUnlock) begin
					state_reg <= HS_WAIT;
					waitCnt_reg <= 32'h00000000;
				end
				HS_WAIT: begin
					// Settle time before any byte
					if (waitCnt_reg >= 32'(RESET_WAIT - 1)) begin
						state_reg <= HS_SEND;
						bitCnt_reg <= 16'h0000;
						bitIdx_reg <= 4'h0;
						byteIdx_reg <= 3'h0;
					end else begin
						waitCnt_reg <= waitCnt_reg + 32'h00000001;
					end
				end
				HS_SEND: begin
					if (bitCnt_reg != 16'(BIT_CYC - 1)) begin
						bitCnt_reg <= bitCnt_reg + 16'h0001;
					end else begin
						bitCnt_reg <= 16'h0000;
						if (bitIdx_reg != 4'h9) begin
							bitIdx_reg <= bitIdx_reg + 4'h1;
						end else begin
							bitIdx_reg <= 4'h0;
							if (byteIdx_reg == 3'h6) begin
								state_reg <= HS_DONE;
							end else begin
								byteIdx_reg <= byteIdx_reg + 3'h1;
							end
						end
					end
				end
				HS_DONE: if (!startUnlock) begin
					state_reg <= HS_IDLE;
				end
			endcase
		end
	end

	// Reset pin low through the wait and the five unlock frames only
	assign link.resetPinN = !(state_reg == HS_WAIT ||
		(state_reg == HS_SEND && byteIdx_reg <= 3'h4));
	assign link.hostDbgOut = 1'b0;
	assign link.hostDbgOe = state_reg == HS_SEND && !frame[bitIdx_reg];
	assign busy = state_reg == HS_WAIT || state_reg == HS_SEND;
	assign done = state_reg == HS_DONE;
endmodule
`default_nettype wire

/* dbu_link_properties.sv */
// Concurrent checks on the unlock link, break handling and runtime count.
// Assumes one core clock; the testbench instantiates it beside the link.
`timescale 1ns/10ps
`default_nettype none
module dbu_link_properties
	import dbu_pkg::*;
#(
	// Host reset settling wait, in cycles
	parameter int RESET_WAIT = RESET_WAIT_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Link signals
	input wire logic resetPinN,
	input wire logic hostDbgOe,
	// Processor side
	input wire logic opcodeValid,
	input wire logic [7:0] opcode,
	input wire logic breakEnable,
	input wire logic leaveDebug,
	input wire logic cpuIdle,
	input wire logic breakNop,
	// Device status
	input wire logic pinIsDebug,
	input wire logic debugMode,
	input wire logic [15:0] runtimeCount
);
	// Break opcode decoded this cycle
	logic brkSeen;
	// Cycles the reset pin has been low; saturates, never wraps
	logic [31:0] lowCnt_reg;
	assign brkSeen = opcodeValid && (opcode == BREAK_OPCODE);
	// Hold-time counter of the shared reset pin
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lowCnt_reg <= 32'h0;
		end else if (resetPinN) begin
			lowCnt_reg <= 32'h0;
		end else if (lowCnt_reg != 32'hFFFFFFFF) begin
			lowCnt_reg <= lowCnt_reg + 32'h1;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	chk_wait_before_key: assert property (
		hostDbgOe && !resetPinN |-> lowCnt_reg >= 32'(RESET_WAIT - 1))
		else $error("host drove the wire before the reset wait");
	chk_unlock_in_reset: assert property (
		$rose(pinIsDebug) |-> !resetPinN)
		else $error("pin unlocked outside reset");
	chk_pin_stands: assert property (pinIsDebug |=> pinIsDebug)
		else $error("debug pin fell back");
	chk_break_enter: assert property (
		brkSeen && breakEnable |=> debugMode && cpuIdle)
		else $error("enabled break did not enter debug");
	chk_break_nop: assert property (
		brkSeen && !breakEnable && !debugMode |=> breakNop && !debugMode)
		else $error("disabled break not a no-op");
	chk_idle_follows: assert property (cpuIdle == debugMode)
		else $error("processor idle differs from debug mode");
	chk_count_frozen: assert property (
		debugMode && !leaveDebug |=> $stable(runtimeCount))
		else $error("runtime count moved in debug");
	chk_count_restart: assert property (
		debugMode && leaveDebug && !(brkSeen && breakEnable)
		|=> runtimeCount == RUNTIME_ZERO)
		else $error("runtime count not restarted");
	chk_count_step: assert property (
		!debugMode && !brkSeen && runtimeCount != RUNTIME_MAX
		|=> runtimeCount == $past(runtimeCount) + 16'h1)
		else $error("runtime count missed a cycle");
	chk_count_hold: assert property (
		!debugMode && runtimeCount == RUNTIME_MAX
		|=> runtimeCount == RUNTIME_MAX)
		else $error("runtime count wrapped");
	// Main scenarios reached
	cover property ($rose(pinIsDebug));
	cover property (brkSeen && breakEnable);
	cover property (breakNop);
	cover property (runtimeCount == RUNTIME_MAX);
endmodule
`default_nettype wire

/* tb_debug_unlock_breakpoint_unit.sv */
// Testbench: host and device joined, plus a second device fed a bad key.
// Assumes the package and link interface are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_debug_unlock_breakpoint_unit;
	import dbu_pkg::*;
	// Short reset wait keeps the run brief
	localparam int WAIT = 50;
	logic core_clk = 1'b0, rst_n = 1'b0, startUnlock = 1'b0, busy, done;
	logic opcodeValid = 1'b0, breakEnable = 1'b0, leaveDebug = 1'b0;
	logic [7:0] opcode = 8'hFF;
	logic gpioOut = 1'b1, gpioOe = 1'b0, dbgTxOut = 1'b1;
	logic cpuIdle, breakNop, pinIsDebug, debugMode, pinIsDebug2;
	logic gpioIn, dbgRxIn;
	logic [15:0] runtimeCount;
	int n_errors = 0, total_checks = 0, cycles = 0;
	// Autobaud, unlock key, then re-autobaud and debug entry write
	logic [7:0] keyBytes [7] = '{AUTOBAUD_BYTE, KEY_BYTE0, KEY_BYTE1,
		KEY_BYTE2, KEY_BYTE3, AUTOBAUD_BYTE, DEBUG_ENTER_CMD};
	dbu_link_if link();
	dbu_link_if link2();
	dbu_host #(.RESET_WAIT(WAIT)) dbu_host_i (.core_clk(core_clk),
		.rst_n(rst_n), .startUnlock(startUnlock), .busy(busy),
		.done(done), .link(link.host));
	dbu_device dbu_device_i (.core_clk(core_clk), .rst_n(rst_n),
		.link(link.device), .opcodeValid(opcodeValid), .opcode(opcode),
		.breakEnable(breakEnable), .leaveDebug(leaveDebug),
		.cpuIdle(cpuIdle), .breakNop(breakNop), .gpioOut(gpioOut),
		.gpioOe(gpioOe), .gpioIn(gpioIn), .dbgTxOut(dbgTxOut),
		.dbgRxIn(dbgRxIn),
		.pinIsDebug(pinIsDebug), .debugMode(debugMode),
		.runtimeCount(runtimeCount));
	// Second device: its host side is driven by the bench with a bad key
	dbu_device dbu_device_b_i (.core_clk(core_clk), .rst_n(rst_n),
		.link(link2.device), .opcodeValid(opcodeValid), .opcode(opcode),
		.breakEnable(breakEnable), .leaveDebug(leaveDebug), .cpuIdle(),
		.breakNop(), .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioIn(),
		.dbgTxOut(dbgTxOut), .dbgRxIn(), .pinIsDebug(pinIsDebug2),
		.debugMode(), .runtimeCount());
	dbu_link_properties #(.RESET_WAIT(WAIT)) dbu_link_properties_i (
		.core_clk(core_clk), .rst_n(rst_n), .resetPinN(link.resetPinN),
		.hostDbgOe(link.hostDbgOe), .opcodeValid(opcodeValid),
		.opcode(opcode), .breakEnable(breakEnable),
		.leaveDebug(leaveDebug), .cpuIdle(cpuIdle), .breakNop(breakNop),
		.pinIsDebug(pinIsDebug), .debugMode(debugMode),
		.runtimeCount(runtimeCount));
	// 40 MHz core clock
	always #12.5 core_clk = ~core_clk;
	// Hang guard, well above the expected run
	always @(posedge core_clk) begin
		cycles = cycles + 1;
		if (cycles == 80000) begin
			n_errors = n_errors + 1;
			finish_test();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (n_errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Decode one 8N1 frame off the joined wire, LSB first
	task automatic rx_byte(output logic [7:0] b, output int waited);
		waited = 0;
		while (link.dbgWire !== 1'b0 && waited < 4000) begin
			@(negedge core_clk);
			waited++;
		end
		repeat (8) @(negedge core_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(negedge core_clk);
			b[i] = link.dbgWire;
		end
		repeat (BIT_CYC) @(negedge core_clk);
		check(16'(link.dbgWire), 16'h1);
	endtask
	// Port pin drive reaches the wire while locked
	task automatic t_gpio();
		gpioOut = 1'b0;
		gpioOe = 1'b1;
		repeat (3) @(negedge core_clk);
		check(16'(link.dbgWire), 16'h0);
		check(16'(pinIsDebug), 16'h0);
		check(16'(gpioIn), 16'h0);
		check(16'(dbgRxIn), 16'h1);
		gpioOe = 1'b0;
		@(negedge core_clk);
	endtask
	// Full unlock, wire contents watched, then debug pin behaviour
	task automatic t_unlock();
		logic [7:0] b;
		int waited;
		startUnlock = 1'b1;
		for (int k = 0; k < 7; k++) begin
			rx_byte(b, waited);
			check(16'(link.resetPinN), 16'(k > 4));
			check(16'(busy), 16'h1);
			check(16'(b), 16'(keyBytes[k]));
			if (k == 0) check(16'(waited >= WAIT), 16'h1);
			if (k == 4) check(16'(pinIsDebug), 16'h1);
		end
		check(16'(pinIsDebug), 16'h1);
		waited = 0;
		while (done !== 1'b1 && waited < 200) begin
			@(negedge core_clk);
			waited++;
		end
		check(16'(done), 16'h1);
		startUnlock = 1'b0;
		repeat (2) @(negedge core_clk);
		check(16'(link.resetPinN), 16'h1);
		check(16'(busy), 16'h0);
		gpioOe = 1'b1;
		repeat (3) @(negedge core_clk);
		check(16'(link.dbgWire), 16'h1);
		gpioOe = 1'b0;
		dbgTxOut = 1'b0;
		repeat (3) @(negedge core_clk);
		check(16'(link.dbgWire), 16'h0);
		check(16'(dbgRxIn), 16'h0);
		check(16'(gpioIn), 16'h1);
		dbgTxOut = 1'b1;
	endtask
	// Bench host on the second link, one key byte wrong
	task automatic t_bad_key();
		logic [9:0] f;
		for (int k = 0; k < 5; k++) begin
			f = {1'b1, keyBytes[k] ^ ((k == 3) ? 8'h01 : 8'h00), 1'b0};
			for (int i = 0; i < 10; i++) begin
				link2.hostDbgOe = !f[i];
				repeat (BIT_CYC) @(negedge core_clk);
			end
		end
		repeat (40) @(negedge core_clk);
		check(16'(pinIsDebug2), 16'h0);
		link2.resetPinN = 1'b1;
		repeat (4) @(negedge core_clk);
		check(16'(pinIsDebug2), 16'h0);
	endtask
	// Disabled break is a no-op; another opcode never breaks
	task automatic t_break_nop();
		opcode = BREAK_OPCODE;
		opcodeValid = 1'b1;
		@(negedge core_clk);
		opcodeValid = 1'b0;
		check(16'(breakNop), 16'h1);
		check(16'(debugMode), 16'h0);
		breakEnable = 1'b1;
		opcode = 8'h01;
		opcodeValid = 1'b1;
		@(negedge core_clk);
		opcodeValid = 1'b0;
		check(16'(breakNop), 16'h0);
		check(16'(debugMode), 16'h0);
	endtask
	// Enabled break, frozen count, restart on leaving debug
	task automatic t_break_enter();
		logic [15:0] held;
		// Fetched byte stands for a flash byte patched to 00H
		opcode = BREAK_OPCODE;
		opcodeValid = 1'b1;
		@(negedge core_clk);
		opcodeValid = 1'b0;
		check(16'(debugMode), 16'h1);
		check(16'(cpuIdle), 16'h1);
		held = runtimeCount;
		repeat (10) @(negedge core_clk);
		check(runtimeCount, held);
		leaveDebug = 1'b1;
		@(negedge core_clk);
		leaveDebug = 1'b0;
		check(runtimeCount, RUNTIME_ZERO);
		repeat (5) @(negedge core_clk);
		check(runtimeCount, 16'h0005);
		repeat (65540) @(negedge core_clk);
		check(runtimeCount, RUNTIME_MAX);
	endtask
	initial begin
		link2.resetPinN = 1'b0;
		link2.hostDbgOut = 1'b0;
		link2.hostDbgOe = 1'b0;
		repeat (8) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (WAIT) @(negedge core_clk);
		t_gpio();
		t_bad_key();
		t_unlock();
		t_break_nop();
		t_break_enter();
		finish_test();
	end
endmodule
`default_nettype wire
